// File: hardware_trap_unit.sv
// Purpose: Hardware trap detection, flagging, arbitration and vectoring
// Assumes: Trap condition inputs are one-cycle pulses synchronous to clock
// Notes: Core must assert service_end on return from each hardware trap handler
// Notes: Software traps never open a service level, so they need no service_end
// Notes: Flag bits 12 to 15 always read zero
// Notes: A flag set wins over a clear of the same bit in the same cycle
`timescale 1ns/1ns
`include "hardware_trap_unit_consts.svh"

module hardware_trap_unit (
  input wire logic clock,
  input wire logic reset,
  // Class A conditions, one-cycle pulses
  input wire logic system_request_zero,
  input wire logic stack_overflow_event,
  input wire logic stack_underflow_event,
  input wire logic software_break_event,
  // Class B conditions, one-cycle pulses
  input wire logic system_request_one,
  input wire logic [2:0] memory_protection_event,
  input wire logic undefined_opcode_event,
  input wire logic access_error_event,
  input wire logic protected_instruction_fault_event,
  input wire logic illegal_word_operand_event,
  // Software trap instruction from the core
  input wire logic software_trap_request,
  input wire logic [6:0] software_trap_number,
  // Handler return and flag clearing by software
  input wire logic service_end,
  input wire logic flag_clear_strobe,
  input wire logic [`FLAG_REG_WIDTH-1:0] flag_clear_mask,
  // Vector table placement from the CPU control registers
  input wire logic [`SEGMENT_WIDTH-1:0] vector_segment_register,
  input wire logic [`SPACING_FIELD_WIDTH-1:0] vector_spacing_field,
  // Flags and branch request towards the core
  output logic [`FLAG_REG_WIDTH-1:0] trap_flag_register,
  output logic branch_request,
  output logic [`SEGMENT_WIDTH+`OFFSET_WIDTH-1:0] branch_vector,
  output logic [6:0] branch_trap_number,
  output logic branch_at_trap_priority,
  // Service status for the interrupt controller
  output logic interrupt_block,
  output logic trap_in_service
);

  // Registered state and its next value; the struct holds flags, pending
  // causes, service level, the held software trap and the branch outputs
  hardware_trap_pkg::trap_state_s st;
  hardware_trap_pkg::trap_state_s next_st;

  // Arbitration signals, all combinational
  logic [`FLAG_COUNT-1:0] events;
  logic class_a_any;
  logic class_b_any;
  logic [`FLAG_COUNT-1:0] requests;
  hardware_trap_pkg::service_e level_after_end;
  logic take_reset;
  logic take_a;
  logic take_b;
  logic take_sw;
  logic [6:0] sel_num;
  logic [`FLAG_COUNT-1:0] a_grant;
  logic [`SEGMENT_WIDTH+`OFFSET_WIDTH-1:0] sel_vector;

  // ==========================================================
  // Condition inputs gathered in flag order
  // Bit order here fixes the flag layout that software sees
  always_comb begin
    events = '0;
    events[`FLAG_SYSREQ_ZERO] = system_request_zero;
    events[`FLAG_STACK_OVER] = stack_overflow_event;
    events[`FLAG_STACK_UNDER] = stack_underflow_event;
    events[`FLAG_SOFT_BREAK] = software_break_event;
    events[`FLAG_SYSREQ_ONE] = system_request_one;
    events[`FLAG_PROT_READ] = memory_protection_event[0];
    events[`FLAG_PROT_WRITE] = memory_protection_event[1];
    events[`FLAG_PROT_EXEC] = memory_protection_event[2];
    events[`FLAG_UNDEF_OPCODE] = undefined_opcode_event;
    events[`FLAG_ACCESS_ERROR] = access_error_event;
    events[`FLAG_PROT_INSTR] = protected_instruction_fault_event;
    events[`FLAG_ILLEGAL_OPERAND] = illegal_word_operand_event;
  end

  // ==========================================================
  // Arbitration: reset entry, then class A, then class B, then software trap
  // At most one entry is taken per cycle; losers stay pending in st.pend
  // or in the software slot, which a newer software request overwrites while it waits.
  // Class A may interrupt a class B handler but never another class A one;
  // class B waits until every hardware service has ended.
  always_comb begin
    requests = st.pend | events;
    class_a_any = |requests[`FLAG_CLASS_A_LAST:0];
    class_b_any = |requests[`FLAG_COUNT-1:`FLAG_CLASS_A_LAST+1];
    a_grant = '0;
    sel_num = `TRAP_NUM_RESET;

    // A handler return is seen before a new trap is judged, so a waiting
    // trap enters in the same cycle its blocker ends
    case (st.level)
      hardware_trap_pkg::SVC_NONE: level_after_end = st.level;
      hardware_trap_pkg::SVC_CLASS_B: level_after_end = service_end ? hardware_trap_pkg::SVC_NONE : st.level;
      hardware_trap_pkg::SVC_CLASS_A: level_after_end = service_end ? hardware_trap_pkg::SVC_NONE : st.level;
      hardware_trap_pkg::SVC_A_OVER_B: level_after_end = service_end ? hardware_trap_pkg::SVC_CLASS_B : st.level;
      default: level_after_end = hardware_trap_pkg::SVC_NONE;
    endcase
    take_reset = st.reset_entry;
    // Class A waits only behind another class A service
    take_a = !take_reset && class_a_any &&
             (level_after_end == hardware_trap_pkg::SVC_NONE ||
              level_after_end == hardware_trap_pkg::SVC_CLASS_B);
    // Class B waits behind any hardware trap service
    take_b = !take_reset && !take_a && class_b_any &&
             level_after_end == hardware_trap_pkg::SVC_NONE;
    // Software traps run at CPU priority, only when no hardware entry wins
    take_sw = !take_reset && !take_a && !take_b && (st.sw_pend || software_trap_request);

    if (take_a) begin
      // Fixed order inside class A; each condition has its own vector
      if (requests[`FLAG_SYSREQ_ZERO]) begin
        a_grant[`FLAG_SYSREQ_ZERO] = 1'b1;
        sel_num = `TRAP_NUM_SYSREQ_ZERO;
      end else if (requests[`FLAG_STACK_OVER]) begin
        a_grant[`FLAG_STACK_OVER] = 1'b1;
        sel_num = `TRAP_NUM_STACK_OVER;
      end else if (requests[`FLAG_STACK_UNDER]) begin
        a_grant[`FLAG_STACK_UNDER] = 1'b1;
        sel_num = `TRAP_NUM_STACK_UNDER;
      end else begin
        a_grant[`FLAG_SOFT_BREAK] = 1'b1;
        sel_num = `TRAP_NUM_SOFT_BREAK;
      end
    end else if (take_b) begin
      sel_num = `TRAP_NUM_CLASS_B;
    end else if (take_sw) begin
      sel_num = st.sw_pend ? st.sw_num : software_trap_number;
    end
  end

  // One shared calculator; only the winner's number reaches it
  trap_vector_calc vector_calc (
    .trap_number(sel_num),
    .spacing_field(vector_spacing_field),
    .segment(vector_segment_register),
    .vector_address(sel_vector)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.branch = 1'b0;
    // Set wins over a clear arriving in the same cycle
    next_st.flags = (st.flags & ~(flag_clear_strobe ? flag_clear_mask[`FLAG_COUNT-1:0] : '0)) | events;
    // Granted class A cause leaves the pending set; the others keep waiting
    next_st.pend = requests & ~a_grant;
    next_st.level = level_after_end;

    // Only the winner of arbitration touches the branch and priority state
    if (take_reset) begin
      next_st.reset_entry = 1'b0;
      next_st.branch = 1'b1;
      next_st.hw_priority = 1'b1;
    end else if (take_a) begin
      next_st.branch = 1'b1;
      next_st.hw_priority = 1'b1;
      // On top of class B the level remembers the interrupted service
      next_st.level = (level_after_end == hardware_trap_pkg::SVC_CLASS_B) ?
                      hardware_trap_pkg::SVC_A_OVER_B : hardware_trap_pkg::SVC_CLASS_A;
    end else if (take_b) begin
      // One entry serves every waiting class B cause; flags tell them apart
      next_st.pend[`FLAG_COUNT-1:`FLAG_CLASS_A_LAST+1] = '0;
      next_st.branch = 1'b1;
      next_st.hw_priority = 1'b1;
      next_st.level = hardware_trap_pkg::SVC_CLASS_B;
    end else if (take_sw) begin
      // Software entries leave service level and block untouched
      next_st.branch = 1'b1;
      next_st.hw_priority = 1'b0;
      next_st.sw_pend = 1'b0;
    end

    // A software trap not served this cycle is held, not dropped; a fresh
    // request that meets the service of an older held one takes the slot
    if (software_trap_request && !(take_sw && !st.sw_pend)) begin
      next_st.sw_pend = 1'b1;
      next_st.sw_num = software_trap_number;
    end

    // Vector and number hold until the next branch for a late reader
    if (next_st.branch) begin
      next_st.trap_number = sel_num;
      next_st.vector_address = sel_vector;
    end
    // Block follows the next level so it rises with the entry branch
    next_st.block_requests = next_st.level != hardware_trap_pkg::SVC_NONE;
  end

  // ==========================================================
  // State register; reset arms the reset entry
  // Reset is synchronous, so the reset branch follows the first edge after release
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
      st.level <= hardware_trap_pkg::SVC_NONE;
      st.reset_entry <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  // trap_in_service mirrors interrupt_block so that the interrupt
  // controller and the core can be wired separately
  always_comb begin
    trap_flag_register = `FLAG_REG_RESET;
    trap_flag_register[`FLAG_COUNT-1:0] = st.flags;
    branch_request = st.branch;
    branch_vector = st.vector_address;
    branch_trap_number = st.trap_number;
    branch_at_trap_priority = st.hw_priority;
    interrupt_block = st.block_requests;
    trap_in_service = st.block_requests;
  end

endmodule

// File: hardware_trap_unit_consts.svh
// Purpose: Constants for the hardware trap unit: trap numbers, flag bits, vector layout
// Assumes: Included by the trap unit files only
// Notes: Flag bit positions and spacing field encoding are local choices
//
// Functional notes
// - A hardware trap forces an immediate non-maskable branch to its vector entry.
// - Each trap occurrence sets its own flag bit in the trap flag register.
// - Pending hardware trap preempts execution unless higher-priority trap service runs; the code also holds any class A trap behind any class A service.
// - During hardware trap service, interrupt and event controller requests are blocked.
// - Class A vectors: 0x0008/02, 0x0010/04, 0x0018/06, 0x0020/08.
// - All class B conditions share vector 0x0028, trap number 0A.
// - Software trap reaches any number 00 to 7F, at current CPU priority.
// - Vector segment register gives the segment part of every vector address.
// - Spacing field scales offsets; default spacing is four bytes.
`ifndef HARDWARE_TRAP_UNIT_CONSTS_SVH
`define HARDWARE_TRAP_UNIT_CONSTS_SVH

// ==========================================================
// Trap numbers
`define TRAP_NUM_RESET 7'h00
`define TRAP_NUM_SYSREQ_ZERO 7'h02
`define TRAP_NUM_STACK_OVER 7'h04
`define TRAP_NUM_STACK_UNDER 7'h06
`define TRAP_NUM_SOFT_BREAK 7'h08
`define TRAP_NUM_CLASS_B 7'h0A

// ==========================================================
// Flag bit positions in the trap flag register
`define FLAG_SYSREQ_ZERO 0
`define FLAG_STACK_OVER 1
`define FLAG_STACK_UNDER 2
`define FLAG_SOFT_BREAK 3
`define FLAG_SYSREQ_ONE 4
`define FLAG_PROT_READ 5
`define FLAG_PROT_WRITE 6
`define FLAG_PROT_EXEC 7
`define FLAG_UNDEF_OPCODE 8
`define FLAG_ACCESS_ERROR 9
`define FLAG_PROT_INSTR 10
`define FLAG_ILLEGAL_OPERAND 11
`define FLAG_COUNT 12
`define FLAG_CLASS_A_LAST 3

// ==========================================================
// Register widths, reset values and vector layout
`define FLAG_REG_WIDTH 16
`define FLAG_REG_RESET 16'h0000
`define SEGMENT_WIDTH 8
`define OFFSET_WIDTH 16
`define SPACING_FIELD_WIDTH 2
`define BASE_SPACING_SHIFT 3'h2

`endif

// File: hardware_trap_pkg.sv
// Purpose: Types shared by the hardware trap unit
// Assumes: Constants header is included first
// Notes: State of the top module is one packed struct
`include "hardware_trap_unit_consts.svh"

package hardware_trap_pkg;

  // Service nesting: class A may sit on top of an interrupted class B service
  typedef enum logic [1:0] {
    SVC_NONE,
    SVC_CLASS_B,
    SVC_CLASS_A,
    SVC_A_OVER_B
  } service_e;

  typedef struct packed {
    logic [`FLAG_COUNT-1:0] flags;
    logic [`FLAG_COUNT-1:0] pend;
    service_e level;
    logic reset_entry;
    logic sw_pend;
    logic [6:0] sw_num;
    logic branch;
    logic hw_priority;
    logic [6:0] trap_number;
    logic [`SEGMENT_WIDTH+`OFFSET_WIDTH-1:0] vector_address;
    logic block_requests;
  } trap_state_s;

endpackage

// File: trap_vector_calc.sv
// Purpose: Turns a trap number into a full vector address
// Assumes: Spacing field 0 means four bytes, each step doubles it
// Notes: Pure combinational, no state
`timescale 1ns/1ns
`include "hardware_trap_unit_consts.svh"

module trap_vector_calc (
  input wire logic [6:0] trap_number,
  input wire logic [`SPACING_FIELD_WIDTH-1:0] spacing_field,
  input wire logic [`SEGMENT_WIDTH-1:0] segment,
  output logic [`SEGMENT_WIDTH+`OFFSET_WIDTH-1:0] vector_address
);

  logic [2:0] shift;
  logic [`OFFSET_WIDTH-1:0] offset;

  // ==========================================================
  // Offset scales with spacing; 7-bit number shifted at most 5 fits 16 bits
  always_comb begin
    shift = 3'({1'b0, spacing_field}) + `BASE_SPACING_SHIFT;
    offset = 16'(trap_number) << shift;
    vector_address = {segment, offset};
  end

endmodule

// File: hardware_trap_unit_checker.sv
// Purpose: Port checker for the trap unit
// Assumes: One clock, synchronous reset
// Notes: Attached by the bind below the module
`timescale 1ns/1ns
`include "hardware_trap_unit_consts.svh"
module hardware_trap_unit_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic system_request_zero,
  input wire logic stack_overflow_event,
  input wire logic system_request_one,
  input wire logic [2:0] memory_protection_event,
  input wire logic service_end,
  input wire logic [`SEGMENT_WIDTH-1:0] vector_segment_register,
  input wire logic [`SPACING_FIELD_WIDTH-1:0] vector_spacing_field,
  input wire logic [`FLAG_REG_WIDTH-1:0] trap_flag_register,
  input wire logic branch_request,
  input wire logic [`SEGMENT_WIDTH+`OFFSET_WIDTH-1:0] branch_vector,
  input wire logic [6:0] branch_trap_number,
  input wire logic branch_at_trap_priority,
  input wire logic interrupt_block,
  input wire logic trap_in_service
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ====================
  // Entry steps
  sequence hw_entry(logic [6:0] n);
    branch_request && branch_at_trap_priority && branch_trap_number == n;
  endsequence
  vector_math_a: assert property (branch_request |-> branch_vector ==
    {$past(vector_segment_register), 16'(branch_trap_number) << (2 + $past(vector_spacing_field))})
    else $error("vector address wrong");
  flag_set_a: assert property (memory_protection_event[1] |=> trap_flag_register[`FLAG_PROT_WRITE])
    else $error("flag not set");
  // Past reset excluded: the reset entry wins that cycle
  class_a_entry_a: assert property (stack_overflow_event && !trap_in_service && !system_request_zero
    && !$past(reset) |=> hw_entry(7'h04)) else $error("class A entry missing");
  a_beats_b_a: assert property (system_request_zero && system_request_one && !trap_in_service
    && !$past(reset) |=> hw_entry(7'h02)) else $error("class B won over class A");
  b_waits_a: assert property (trap_in_service && system_request_one && !service_end |=>
    !(branch_request && branch_at_trap_priority && branch_trap_number == 7'h0A))
    else $error("class B entered in service");
  block_holds_a: assert property (interrupt_block && !service_end |=> interrupt_block)
    else $error("block dropped early");
  block_on_entry_a: assert property (branch_request && branch_at_trap_priority &&
    branch_trap_number != 7'h00 |-> interrupt_block) else $error("block missing");
  no_reserved_a: assert property (branch_request && branch_at_trap_priority |->
    branch_trap_number inside {7'h00, 7'h02, 7'h04, 7'h06, 7'h08, 7'h0A}) else $error("bad hardware number");
endmodule
bind hardware_trap_unit hardware_trap_unit_checker checker_i (.clock, .reset, .system_request_zero,
  .stack_overflow_event, .system_request_one, .memory_protection_event, .service_end, .vector_segment_register,
  .vector_spacing_field, .trap_flag_register, .branch_request, .branch_vector, .branch_trap_number,
  .branch_at_trap_priority, .interrupt_block, .trap_in_service);

// File: trap_core_model.sv
// Purpose: Core side returning from trap handlers
// Assumes: Handler length is lag plus one cycles
// Notes: Counts nested hardware entries
`timescale 1ns/1ns
module trap_core_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] lag,
  input wire logic branch_request,
  input wire logic branch_at_trap_priority,
  input wire logic [6:0] branch_trap_number,
  output logic service_end
);
  logic [1:0] depth;
  logic [7:0] left;
  // Reset and software entries open no handler to return from
  always_ff @(posedge clock) begin
    service_end <= 1'b0;
    if (reset) begin
      depth <= 2'h0;
      left <= 8'h00;
    end else if (branch_request && branch_at_trap_priority && branch_trap_number != 7'h00) begin
      depth <= depth + 2'h1;
      left <= lag;
    end else if (depth != 2'h0) begin
      if (left == 8'h00) begin
        service_end <= 1'b1;
        depth <= depth - 2'h1;
        left <= lag;
      end else begin
        left <= left - 8'h01;
      end
    end
  end
endmodule

// File: hardware_trap_unit_bench.sv
// Purpose: Self-checking bench for the trap unit
// Assumes: Inputs change 1 ns after the edge
// Notes: Flag bit i follows event bit i
`timescale 1ns/1ns
module hardware_trap_unit_bench;
  logic clock, reset, sw_req, clr, done, br, pri, blk, svc;
  logic [11:0] ev;
  logic [6:0] sw_num, num;
  logic [7:0] seg, lag;
  logic [1:0] spc;
  logic [15:0] flags, want, mask;
  logic [23:0] vec;
  int n_mismatch, check_count;
  hardware_trap_unit hardware_trap_unit_i (.clock(clock), .reset(reset), .system_request_zero(ev[0]),
    .stack_overflow_event(ev[1]), .stack_underflow_event(ev[2]), .software_break_event(ev[3]),
    .system_request_one(ev[4]), .memory_protection_event(ev[7:5]), .undefined_opcode_event(ev[8]),
    .access_error_event(ev[9]), .protected_instruction_fault_event(ev[10]), .illegal_word_operand_event(ev[11]),
    .software_trap_request(sw_req), .software_trap_number(sw_num), .service_end(done), .flag_clear_strobe(clr),
    .flag_clear_mask(mask), .vector_segment_register(seg), .vector_spacing_field(spc),
    .trap_flag_register(flags), .branch_request(br), .branch_vector(vec), .branch_trap_number(num),
    .branch_at_trap_priority(pri), .interrupt_block(blk), .trap_in_service(svc));
  trap_core_model trap_core_model_i (.clock(clock), .reset(reset), .lag(lag), .branch_request(br),
    .branch_at_trap_priority(pri), .branch_trap_number(num), .service_end(done));
  // ====================
  // Tasks
  task automatic check(input string what, input logic [39:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One request, then the entry it must cause
  task automatic go(input logic [11:0] e, input logic s, input logic [6:0] n);
    ev = e;
    sw_req = s;
    sw_num = n;
    want |= 16'(e);
    tick(1);
    ev = 12'h000;
    sw_req = 1'b0;
    check("branch", br, 1'b1);
    check("number", num, n);
    check("vector", vec, {seg, 16'(n) << (2 + spc)});
    check("priority", pri, !s);
    check("block", blk, !s);
    check("service", svc, !s);
    check("flags", flags, want);
  endtask
  task automatic wait_br(input logic [6:0] n);
    tick(1);
    for (int i = 0; i < 100 && br !== 1'b1; i++) tick(1);
    check("late number", num, n);
  endtask
  // Bounded wait so a stuck block cannot hang the run
  task automatic settle;
    for (int i = 0; i < 300 && blk !== 1'b0; i++) tick(1);
    check("settled", blk, 1'b0);
    mask = 16'hFFFF;
    clr = 1'b1;
    want = 16'h0000;
    tick(1);
    clr = 1'b0;
    check("cleared", flags, 16'h0000);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #200000;
    n_mismatch++;
    results;
  end
  // ====================
  // Scenarios
  initial begin
    {reset, sw_req, clr, ev, sw_num, spc, want} = '0;
    reset = 1'b1;
    mask = 16'hFFFF;
    seg = 8'h5A;
    lag = 8'h03;
    tick(16);
    reset = 1'b0;
    tick(1);
    check("reset entry", {br, pri, num, vec}, {2'b11, 7'h00, seg, 16'h0000});
    tick(2);
    for (int i = 0; i < 4; i++) begin
      go(12'h001 << i, 1'b0, 7'(2 * i + 2));
      settle;
    end
    for (int i = 4; i < 12; i++) begin
      go(12'h001 << i, 1'b0, 7'h0A);
      settle;
    end
    for (int f = 0; f < 4; f++) begin
      spc = 2'(f);
      seg = 8'hA0 + 8'(f);
      go(12'h002, 1'b0, 7'h04);
      settle;
      go(12'h000, 1'b1, 7'h7F);
      tick(1);
      go(12'h000, 1'b1, 7'h0B);
      tick(1);
    end
    spc = 2'h0;
    lag = 8'd20;
    go(12'h011, 1'b0, 7'h02);
    wait_br(7'h0A);
    go(12'h004, 1'b0, 7'h06);
    tick(1);
    ev = 12'h011;
    want |= 16'h0011;
    tick(1);
    ev = 12'h000;
    check("held", br, 1'b0);
    wait_br(7'h02);
    settle;
    // Set and clear of one bit in one cycle, then a partial clear
    ev = 12'h006;
    clr = 1'b1;
    mask = 16'h0002;
    tick(1);
    ev = 12'h000;
    mask = 16'h0004;
    check("set wins", flags, 16'h0006);
    tick(1);
    clr = 1'b0;
    check("part clear", flags, 16'h0002);
    settle;
    results;
  end
endmodule
